// >>> hdl/mtw_master.sv
// Two-wire bus master with APB register access
`timescale 1ns/1ps

module mtw_master
  import mtw_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic               pslverr,
  output logic [31:0]        prdata,
  // Bus pins
  input  wire mtw_pins_in_t  pins_in,
  output mtw_pins_out_t      pins_out,
  // Interrupt
  output logic               irq,
  output logic               irq_priority_high
);

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_START = 7'b0000010,
    ST_WAIT  = 7'b0000100,
    ST_BIT   = 7'b0001000,
    ST_ACK   = 7'b0010000,
    ST_STOP  = 7'b0100000,
    ST_HOLD  = 7'b1000000
  } mtw_state_t;

  mtw_state_t    state_ff;
  logic [7:0]    control_ff;
  logic [7:0]    shift_ff;
  logic [IRQ_BITS-1:0] status_ff;
  logic [IRQ_BITS-1:0] mask_ff;
  logic          prio_ff;
  logic [1:0]    sda_sync_ff;
  logic [1:0]    scl_sync_ff;
  logic [6:0]    tick_cnt_ff;
  logic [1:0]    phase_ff;
  logic [2:0]    bit_cnt_ff;
  logic          rx_mode_ff;
  logic          sda_drv_ff;
  logic          scl_drv_ff;
  logic          byte_done;
  logic          nack_seen;
  logic          tick;
  logic [6:0]    qtr_len;
  logic          scl_ready;
  logic          wr_acc;
  logic          rd_acc;
  logic          wr_data;
  logic          rd_data;
  logic          wr_ctrl;
  logic          in_frame;

  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign wr_data  = wr_acc && (paddr == ADDR_SHIFT_DATA);
  assign rd_data  = rd_acc && (paddr == ADDR_SHIFT_DATA);
  assign wr_ctrl  = wr_acc && (paddr == ADDR_CONTROL);
  assign in_frame = (state_ff == ST_WAIT);
  assign pready   = 1'b1;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      sda_sync_ff <= 2'h3;
      scl_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], pins_in.sda_in};
      scl_sync_ff <= {scl_sync_ff[0], pins_in.scl_in};
    end
  end

  // ---------------------------------------------------------------------------
  // Serial clock divider, four phases per bit
  // ---------------------------------------------------------------------------
  always_comb begin
    case (control_ff[1:0])
      2'h0:    qtr_len = QTR_DIV4;
      2'h1:    qtr_len = QTR_DIV16;
      2'h2:    qtr_len = QTR_DIV64;
      default: qtr_len = QTR_DIV256;
    endcase
  end

  assign tick = (tick_cnt_ff == qtr_len - 7'h01);

  always_ff @(posedge mclk) begin
    if (reset || !control_ff[BIT_ENABLE] || state_ff == ST_IDLE || in_frame) begin
      tick_cnt_ff <= 7'h00;
    end else if (tick) begin
      tick_cnt_ff <= 7'h00;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 7'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock stretch detection
  // ---------------------------------------------------------------------------
  // Synchroniser lags two clocks, longer than a quarter at the fastest rate:
  // stretching is honoured only at the slower rates, else /4 would be lost
  assign scl_ready = scl_sync_ff[1] || (control_ff[1:0] == 2'h0);

  // ---------------------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------------------
  // Slaves stretching the clock are honoured in ST_BIT and ST_ACK except at /4: phase 2 waits for scl high
  always_ff @(posedge mclk) begin
    if (reset || !control_ff[BIT_ENABLE]) begin
      state_ff   <= ST_IDLE;
      phase_ff   <= 2'h0;
      bit_cnt_ff <= 3'h7;
      rx_mode_ff <= 1'b0;
      sda_drv_ff <= 1'b1;
      scl_drv_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          sda_drv_ff <= 1'b1;
          scl_drv_ff <= 1'b1;
          if (control_ff[BIT_START]) begin
            state_ff <= ST_START;
            phase_ff <= 2'h0;
          end
        end
        ST_START: if (tick) begin
          phase_ff <= phase_ff + 2'h1;
          if (phase_ff == 2'h1) sda_drv_ff <= 1'b0;
          if (phase_ff == 2'h3) begin
            scl_drv_ff <= 1'b0;
            state_ff   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wr_data) begin
            rx_mode_ff <= 1'b0;
            bit_cnt_ff <= 3'h7;
            phase_ff   <= 2'h0;
            state_ff   <= ST_BIT;
          end else if (rd_data) begin
            rx_mode_ff <= 1'b1;
            bit_cnt_ff <= 3'h7;
            phase_ff   <= 2'h0;
            state_ff   <= ST_BIT;
          end else if (control_ff[BIT_STOP]) begin
            phase_ff <= 2'h0;
            state_ff <= ST_STOP;
          end
        end
        ST_BIT: if (tick && !(phase_ff == 2'h2 && !scl_ready)) begin
          phase_ff <= phase_ff + 2'h1;
          case (phase_ff)
            2'h0: sda_drv_ff <= rx_mode_ff ? 1'b1 : shift_ff[bit_cnt_ff];
            2'h1: scl_drv_ff <= 1'b1;
            2'h2: ;
            default: begin
              scl_drv_ff <= 1'b0;
              if (bit_cnt_ff == 3'h0) state_ff <= ST_ACK;
              bit_cnt_ff <= bit_cnt_ff - 3'h1;
            end
          endcase
        end
        ST_ACK: if (tick && !(phase_ff == 2'h2 && !scl_ready)) begin
          phase_ff <= phase_ff + 2'h1;
          case (phase_ff)
            2'h0: sda_drv_ff <= rx_mode_ff ? control_ff[BIT_ACK_SEL] : 1'b1;
            2'h1: scl_drv_ff <= 1'b1;
            2'h2: ;
            default: begin
              scl_drv_ff <= 1'b0;
              state_ff   <= control_ff[BIT_STOP] ? ST_STOP : ST_WAIT;
            end
          endcase
        end
        ST_STOP: if (tick) begin
          phase_ff <= phase_ff + 2'h1;
          case (phase_ff)
            2'h0: sda_drv_ff <= 1'b0;
            2'h1: scl_drv_ff <= 1'b1;
            2'h2: sda_drv_ff <= 1'b1;
            default: state_ff <= ST_HOLD;
          endcase
        end
        default: if (!control_ff[BIT_START]) state_ff <= ST_IDLE;
      endcase
    end
  end

  assign byte_done = (state_ff == ST_ACK) && tick && (phase_ff == 2'h3);
  assign nack_seen = byte_done && !rx_mode_ff && sda_sync_ff[1];

  // ---------------------------------------------------------------------------
  // Shift data register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_ff <= DATA_RESET;
    end else if (wr_data) begin
      shift_ff <= pwdata[7:0];
    end else if (state_ff == ST_BIT && rx_mode_ff && tick && phase_ff == 2'h2 && scl_ready) begin
      shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // Start request drops once the stop sequence has finished
  always_ff @(posedge mclk) begin
    if (reset) begin
      control_ff <= CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        control_ff[7:6] <= pwdata[7:6];
        control_ff[3:0] <= pwdata[3:0];
      end else if (state_ff == ST_HOLD) begin
        control_ff[BIT_START] <= 1'b0;
      end
      // Set wins over a simultaneous software clear
      if (byte_done) begin
        control_ff[BIT_DONE] <= 1'b1;
      end else if (wr_ctrl && !pwdata[BIT_DONE]) begin
        control_ff[BIT_DONE] <= 1'b0;
      end
      if (byte_done && !rx_mode_ff) begin
        control_ff[BIT_ACK_IN] <= sda_sync_ff[1];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status, mask, priority
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= ((rd_acc && paddr == ADDR_IRQ_STATUS) ? '0 : status_ff)
                   | {nack_seen, byte_done};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_ff <= '0;
      prio_ff <= 1'b0;
    end else if (wr_acc && paddr == ADDR_IRQ_MASK) begin
      mask_ff <= pwdata[IRQ_BITS-1:0];
    end else if (wr_acc && paddr == ADDR_PRIORITY) begin
      prio_ff <= pwdata[BIT_PRIO_HI];
    end
  end

  assign irq               = |(status_ff & mask_ff);
  assign irq_priority_high = prio_ff;

  // ---------------------------------------------------------------------------
  // Read data and error answer
  // ---------------------------------------------------------------------------
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == ADDR_CONTROL) begin
      prdata = {24'h00_0000, control_ff};
    end else if (paddr == ADDR_SHIFT_DATA) begin
      prdata = {24'h00_0000, shift_ff};
    end else if (paddr == ADDR_IRQ_MASK) begin
      prdata = {30'h0000_0000, mask_ff};
    end else if (paddr == ADDR_IRQ_STATUS) begin
      prdata = {30'h0000_0000, status_ff};
    end else if (paddr == ADDR_PRIORITY) begin
      prdata = {27'h000_0000, prio_ff, 4'h0};
    end else begin
      pslverr = psel && penable;
    end
  end

  // Open drain: low driven only, enable low while driving
  assign pins_out = '{sda_out:  1'b0,
                      sda_oe_n: sda_drv_ff,
                      scl_out:  1'b0,
                      scl_oe_n: scl_drv_ff};

endmodule : mtw_master

// >>> hdl/mtw_pkg.sv
// Package for the two-wire bus master: offsets, fields, reset values, carriers
package mtw_pkg;
  // ---------------------------------------------------------------------------
  // Register indices (printed offsets are not word aligned; byte addr = 4*index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_CONTROL    = 8'he1;
  localparam logic [7:0]  IDX_SHIFT_DATA = 8'he2;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'hf0;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'hf1;
  localparam logic [7:0]  IDX_PRIORITY   = 8'hf2;
  localparam logic [11:0] ADDR_CONTROL    = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_SHIFT_DATA = {2'h0, IDX_SHIFT_DATA, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_PRIORITY   = {2'h0, IDX_PRIORITY, 2'h0};

  // ---------------------------------------------------------------------------
  // Control register fields, priority register bit, reset values
  // ---------------------------------------------------------------------------
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_ACK_SEL  = 6;
  localparam int BIT_DONE     = 5;
  localparam int BIT_ACK_IN   = 4;
  localparam int BIT_START    = 3;
  localparam int BIT_STOP     = 2;
  localparam int BIT_PRIO_HI  = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  // Interrupt status bits: byte done, nack seen
  localparam int IRQ_BITS     = 2;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_NACK     = 1;

  // ---------------------------------------------------------------------------
  // Rate codes: quarter-period counts for div 4/16/64/256
  // ---------------------------------------------------------------------------
  localparam logic [6:0] QTR_DIV4   = 7'h01;
  localparam logic [6:0] QTR_DIV16  = 7'h04;
  localparam logic [6:0] QTR_DIV64  = 7'h10;
  localparam logic [6:0] QTR_DIV256 = 7'h40;

  typedef struct packed {
    logic sda_in;
    logic scl_in;
  } mtw_pins_in_t;

  typedef struct packed {
    logic sda_out;
    logic sda_oe_n;
    logic scl_out;
    logic scl_oe_n;
  } mtw_pins_out_t;
endpackage : mtw_pkg

// >>> verification/mtw_master_test.sv
// Bench for the two-wire master
`timescale 1ns/1ps
module mtw_master_test;
  import mtw_pkg::*;
  logic          mclk = 1'b0;
  logic          reset = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, q;
  logic          pready, pslverr, irq, prio, pull, ack_seen, err, scl_d;
  logic          send_mode = 1'b0;
  logic          nack = 1'b0;
  logic [7:0]    tx_byte = 8'h0;
  logic [7:0]    rx_byte;
  mtw_pins_in_t  pins_in;
  mtw_pins_out_t pins_out;
  wire           scl_w = pins_out.scl_oe_n;
  wire           sda_w = pins_out.sda_oe_n && !pull;
  int            n_mismatch = 0;
  int            num_checks = 0;
  int            cyc = 0;
  int            run = 0;
  int            per = 0;
  assign pins_in = {sda_w, scl_w};
  always #20 mclk = ~mclk;
  mtw_master dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pins_in(pins_in), .pins_out(pins_out), .irq(irq), .irq_priority_high(prio));
  mtw_slave_model slv_u (.scl(scl_w), .sda(sda_w), .send_mode(send_mode), .nack(nack),
    .tx_byte(tx_byte), .sda_pull(pull), .rx_byte(rx_byte), .ack_seen(ack_seen));
  // Bus clock period in system clocks, and the hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    scl_d <= scl_w;
    run <= (scl_w && !scl_d) ? 1 : run + 1;
    if (scl_w && !scl_d) per <= run;
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q, e);
  endtask : rd
  task automatic start(input logic [31:0] c);
    apb(1'b1, ADDR_CONTROL, c);
    for (int i = 0; i < 600 && scl_w !== 1'b0; i++) @(posedge mclk);
  endtask : start
  task automatic wait_done();
    q = 32'h0;
    for (int i = 0; i < 1500 && q[BIT_DONE] !== 1'b1; i++) apb(1'b0, ADDR_CONTROL, 32'h0);
  endtask : wait_done
  // Stop request with the done flag written as zero
  task automatic stop(input logic [31:0] c);
    apb(1'b1, ADDR_CONTROL, c | 32'h0c);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check({31'h0, q[BIT_DONE]}, 32'h0);
    for (int i = 0; i < 900 && q[BIT_START] !== 1'b0; i++) apb(1'b0, ADDR_CONTROL, 32'h0);
    check({30'h0, sda_w, scl_w}, 32'h3);
  endtask : stop
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(ADDR_CONTROL, 32'h04);
    rd(ADDR_SHIFT_DATA, 32'h0);
    rd(ADDR_PRIORITY, 32'h0);
    rd(12'h000, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_PRIORITY, 32'h10);
    rd(ADDR_PRIORITY, 32'h10);
    check({31'h0, prio}, 32'h1);
    apb(1'b1, ADDR_SHIFT_DATA, 32'h5a);
    rd(ADDR_SHIFT_DATA, 32'h5a);
    apb(1'b1, ADDR_CONTROL, 32'h08);
    repeat (40) @(posedge mclk);
    check({30'h0, pins_out.scl_oe_n, pins_out.sda_oe_n}, 32'h3);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      nack <= r[0];
      apb(1'b1, ADDR_IRQ_MASK, {31'h0, r != 2});
      start(32'h88 | r);
      apb(1'b1, ADDR_SHIFT_DATA, 32'ha5 ^ r);
      wait_done();
      check({30'h0, q[BIT_DONE], q[BIT_ACK_IN]}, {30'h0, 1'b1, r[0]});
      check({24'h0, rx_byte}, 32'ha5 ^ r);
      check(per, 4 << (2 * r));
      check({31'h0, irq}, {31'h0, r != 2});
      rd(ADDR_IRQ_STATUS, {30'h0, r[0], 1'b1});
      #1;
      check({31'h0, irq}, 32'h0);
      stop(32'h80 | r);
      $display("test send rate %0d done", r);
    end
    for (int a = 0; a < 2; a++) begin
      tx_byte <= 8'h3c + 8'(a);
      send_mode <= 1'b1;
      start(32'h88 | (a << 6));
      apb(1'b0, ADDR_SHIFT_DATA, 32'h0);
      wait_done();
      check({31'h0, ack_seen}, a);
      rd(ADDR_SHIFT_DATA, 32'h3c + a);
      send_mode <= 1'b0;
      stop(32'h80 | (a << 6));
      $display("test receive ack %0d done", a);
    end
    conclude();
  end
endmodule : mtw_master_test

// >>> verification/mtw_properties.sv
// Port-level checker for the two-wire master
`timescale 1ns/1ps
module mtw_properties
  import mtw_pkg::*;
(
  // Clock and reset
  input wire logic          mclk,
  input wire logic          reset,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [31:0]   prdata,
  // Pins and interrupt
  input wire mtw_pins_in_t  pins_in,
  input wire mtw_pins_out_t pins_out,
  input wire logic          irq,
  input wire logic          irq_priority_high
);
  logic       acc;
  logic       map;
  logic       en_ff;
  logic [1:0] rate_ff;
  assign acc = psel && penable;
  assign map = paddr inside {ADDR_CONTROL, ADDR_SHIFT_DATA, ADDR_IRQ_MASK, ADDR_IRQ_STATUS, ADDR_PRIORITY};
  // Software copy of enable and rate
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_ff   <= 1'b0;
      rate_ff <= 2'h0;
    end else if (acc && pwrite && paddr == ADDR_CONTROL) begin
      en_ff   <= pwdata[BIT_ENABLE];
      rate_ff <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_zero_wait: assert property (acc |-> pready) else $error("no ready");
  chk_unmapped_err: assert property (acc && !map |-> pslverr && prdata == 32'h0) else $error("unmapped ok");
  chk_idle_released: assert property (!en_ff && !$past(en_ff) |-> pins_out.scl_oe_n && pins_out.sda_oe_n)
    else $error("bus driven while off");
  chk_reset_state: assert property ($fell(reset) |-> pins_out.scl_oe_n && !irq && !irq_priority_high)
    else $error("bad reset state");
  chk_prio_write: assert property (acc && pwrite && paddr == ADDR_PRIORITY
    |=> irq_priority_high == $past(pwdata[BIT_PRIO_HI])) else $error("prio not written");
  chk_ctrl_read: assert property (acc && !pwrite && paddr == ADDR_CONTROL
    |-> prdata[1:0] == rate_ff && prdata[BIT_ENABLE] == en_ff) else $error("control readback");
  chk_open_drain: assert property (!pins_out.scl_out && !pins_out.sda_out) else $error("pin driven high");
  chk_scl_high: assert property (en_ff && $rose(pins_out.scl_oe_n) |=> pins_out.scl_oe_n)
    else $error("clock high too short");
  cover property (acc && !map);
  cover property ($rose(irq));
  cover property ($fell(pins_out.sda_oe_n) && pins_out.scl_oe_n);
endmodule : mtw_properties

bind mtw_master mtw_properties chk_u (.*);

// >>> verification/mtw_slave_model.sv
// Behavioural slave on the two-wire bus
`timescale 1ns/1ps
module mtw_slave_model (
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour set by the bench
  input  wire logic       send_mode,
  input  wire logic       nack,
  input  wire logic [7:0] tx_byte,
  // Drive and observation
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic            ack_seen
);
  logic [3:0] bit_ff = 4'hf;
  logic       pull_ff = 1'b0;
  // Leaving send mode releases the line so a stop can pass
  assign sda_pull = pull_ff && (send_mode || bit_ff == 4'h8);
  always @(negedge sda) if (scl) bit_ff = 4'hf;
  always @(negedge scl) begin
    bit_ff = (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
    if (bit_ff == 4'h8)
      pull_ff = !send_mode && !nack;
    else
      pull_ff = send_mode && !tx_byte[3'h7 - bit_ff[2:0]];
  end
  always @(posedge scl) begin
    if (bit_ff < 4'h8 && !send_mode) rx_byte = {rx_byte[6:0], sda};
    if (bit_ff == 4'h8 && send_mode) ack_seen = sda;
  end
endmodule : mtw_slave_model
